// file: design/srr_pkg.sv
// srr_pkg: shared constants and carrier structs for the slot result ram read port
// assumes a single 50 MHz system clock domain
package srr_pkg;
    localparam int SRR_ADDR_W = 9;
    localparam int SRR_DATA_W = 9;
    localparam int SRR_DEPTH = 512;
    localparam int SRR_RESULT_W = 12;
    localparam int SRR_SLOT_W = 8;
    localparam int SRR_LO_MSB = 8;
    localparam int SRR_HI_LSB = 9;
    localparam int SRR_HI_W = 3;
    localparam int SRR_CLK_MHZ = 50;
    localparam int SRR_CAL_LATENCY = 14;
    localparam logic [8:0] SRR_ADDR_RESET = 9'h000;
    localparam logic [8:0] SRR_DATA_RESET = 9'h000;
    localparam logic [11:0] SRR_RESULT_RESET = 12'h000;

    typedef enum logic [2:0]
    {
        SRR_IDLE = 3'b001,
        SRR_WR_LO = 3'b010,
        SRR_WR_HI = 3'b100
    } srr_wstate_e;

    // one conversion handed over by the sequencer or correction core
    typedef struct packed
    {
        logic valid;
        logic [SRR_SLOT_W-1:0] slot;
        logic [SRR_RESULT_W-1:0] result;
    } srr_conv_s;

    // one memory write on port b
    typedef struct packed
    {
        logic we;
        logic [SRR_ADDR_W-1:0] addr;
        logic [SRR_DATA_W-1:0] data;
    } srr_wr_s;
endpackage

// file: design/srr_ram.sv
// srr_ram: 512x9 dual-port memory, registered read on port a, write on port b
// assumes both ports run on the system clock
module srr_ram
    import srr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_ce,
    input wire logic i_rd_en,
    input wire logic [SRR_ADDR_W-1:0] i_rd_addr,
    output logic [SRR_DATA_W-1:0] o_rd_data,
    input wire srr_wr_s i_wr
);
    logic [SRR_DATA_W-1:0] mem [SRR_DEPTH];

    // read data registered, one cycle after enable as for block memory
    always_ff @(posedge i_clk)
    begin
        if (i_ce && i_wr.we)
        begin
            mem[i_wr.addr] <= i_wr.data;
        end
        if (i_ce && i_rd_en)
        begin
            o_rd_data <= mem[i_rd_addr];
        end
    end
endmodule

// file: design/srr_top.sv
// srr_top: sequencer result memory with user read port on port a
// assumes conversions arrive on the system clock, at most one every three cycles,
// and user read inputs come from logic on the same clock
module srr_top
    import srr_pkg::*;
#(
    parameter bit CAL_EN = 1'b0
)
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire srr_conv_s i_conv,
    input wire logic [15:0] i_cal_gain,
    input wire logic [15:0] i_cal_offset,
    input wire logic i_internal_port_a_req,
    input wire logic [SRR_ADDR_W-1:0] i_internal_port_a_address,
    input wire logic [SRR_ADDR_W-1:0] i_user_result_ram_address,
    input wire logic i_user_result_ram_read_enable,
    output logic [SRR_DATA_W-1:0] o_result_ram_read_data,
    output logic o_result_ram_port_a_busy,
    output logic o_sequencer_port_b_write_busy,
    output logic [SRR_RESULT_W-1:0] o_conversion_result,
    output logic o_conversion_valid,
    output logic o_conversion_busy
);
    localparam int CAL_CYC = SRR_CAL_LATENCY;

    typedef struct packed
    {
        srr_wstate_e wst;
        logic [SRR_SLOT_W-1:0] slot;
        logic [SRR_RESULT_W-1:0] result;
        logic [CAL_CYC-1:0] vpipe;
        logic [CAL_CYC-1:0][SRR_RESULT_W-1:0] dpipe;
        logic [CAL_CYC-1:0][SRR_SLOT_W-1:0] spipe;
        logic busy;
        logic wbusy;
        logic [SRR_RESULT_W-1:0] out_res;
        logic out_val;
        logic out_busy;
    } srr_state_s;

    srr_state_s st;
    srr_state_s next_st;
    srr_wr_s wr;
    logic [31:0] cal_prod;
    logic [SRR_RESULT_W-1:0] cal_val;
    logic [SRR_RESULT_W-1:0] src_res;
    logic [SRR_SLOT_W-1:0] src_slot;
    logic src_val;
    logic rd_en;
    logic [SRR_ADDR_W-1:0] rd_addr;
    logic [SRR_DATA_W-1:0] ram_q;

    // gain in 8.8 fixed point; saturate rather than wrap on overflow
    always_comb
    begin
        cal_prod = {20'h00000, i_conv.result} * {16'h0000, i_cal_gain};
        cal_prod = (cal_prod >> 8) + {16'h0000, i_cal_offset};
        cal_val = (cal_prod > 32'h00000FFF) ? 12'hFFF : cal_prod[11:0];
    end

    // choose raw or calibrated source for storage and export
    always_comb
    begin
        if (CAL_EN)
        begin
            src_val = st.vpipe[CAL_CYC-1];
            src_res = st.dpipe[CAL_CYC-1];
            src_slot = st.spipe[CAL_CYC-1];
        end
        else
        begin
            src_val = i_conv.valid;
            src_res = i_conv.result;
            src_slot = i_conv.slot;
        end
    end

    // internal agent owns port a while requesting; user read is gated off then
    assign rd_en = i_internal_port_a_req | i_user_result_ram_read_enable;
    assign rd_addr = i_internal_port_a_req ? i_internal_port_a_address
                                           : i_user_result_ram_address;

    // next state: two-word write per conversion, calibration delay line
    always_comb
    begin
        next_st = st;
        wr = '0;
        next_st.vpipe = {st.vpipe[CAL_CYC-2:0], i_conv.valid};
        next_st.dpipe = {st.dpipe[CAL_CYC-2:0], cal_val};
        next_st.spipe = {st.spipe[CAL_CYC-2:0], i_conv.slot};
        next_st.busy = i_internal_port_a_req;
        next_st.out_res = src_res;
        next_st.out_val = src_val;
        next_st.out_busy = (st.vpipe != '0) | i_conv.valid;
        case (st.wst)
            SRR_IDLE:
            begin
                if (src_val)
                begin
                    next_st.slot = src_slot;
                    next_st.result = src_res;
                    next_st.wst = SRR_WR_LO;
                end
            end
            SRR_WR_LO:
            begin
                wr.we = 1'b1;
                wr.addr = {st.slot, 1'b0};
                wr.data = st.result[SRR_LO_MSB:0];
                next_st.wst = SRR_WR_HI;
            end
            SRR_WR_HI:
            begin
                wr.we = 1'b1;
                wr.addr = {st.slot, 1'b1};
                wr.data = {6'h00, st.result[SRR_RESULT_W-1:SRR_HI_LSB]};
                next_st.wst = SRR_IDLE;
            end
            default:
            begin
                next_st.wst = SRR_IDLE;
            end
        endcase
        next_st.wbusy = (next_st.wst != SRR_IDLE);
    end

    // state register; a low clock enable freezes every field, the delay line included
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            st <= '0;
            st.wst <= SRR_IDLE;
        end
        else if (i_ce)
        begin
            st <= next_st;
        end
    end

    srr_ram u_ram
    (
        .i_clk(i_clk),
        .i_ce(i_ce),
        .i_rd_en(rd_en),
        .i_rd_addr(rd_addr),
        .o_rd_data(ram_q),
        .i_wr(wr)
    );

    // user sees the port a word directly from the memory output register
    assign o_result_ram_read_data = ram_q;
    assign o_result_ram_port_a_busy = st.busy;
    assign o_sequencer_port_b_write_busy = st.wbusy;
    assign o_conversion_result = st.out_res;
    assign o_conversion_valid = st.out_val;
    assign o_conversion_busy = st.out_busy;

    property p_wbusy_two;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && st.wst == SRR_IDLE && src_val) ##1 i_ce |=> o_sequencer_port_b_write_busy;
    endproperty
    a_wbusy_two: assert property (p_wbusy_two) else $error("write busy missing");

    // the low word must really land in memory at the slot's even address
    property p_lo_word;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && st.wst == SRR_WR_LO)
            |=> (u_ram.mem[{$past(st.slot), 1'b0}] == 9'($past(st.result)));
    endproperty
    a_lo_word: assert property (p_lo_word) else $error("low word wrong");

    property p_hi_word;
        @(posedge i_clk) disable iff (!i_reset_n)
        (wr.we && st.wst == SRR_WR_HI) |-> (wr.addr == {st.slot, 1'b1} && wr.data[8:3] == 6'h00);
    endproperty
    a_hi_word: assert property (p_hi_word) else $error("high word wrong");

    property p_busy;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && i_internal_port_a_req) |=> o_result_ram_port_a_busy;
    endproperty
    a_busy: assert property (p_busy) else $error("port a busy missing");

    property p_read_lat;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && rd_en && !wr.we) |=> (o_result_ram_read_data == u_ram.mem[$past(rd_addr)]);
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("read data late");

    // busy must fall once the internal agent lets go, or the user waits forever
    property p_busy_drop;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && !i_internal_port_a_req) |=> !o_result_ram_port_a_busy;
    endproperty
    a_busy_drop: assert property (p_busy_drop) else $error("port a busy stuck");

    property p_wbusy_end;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && st.wst == SRR_WR_HI) |=> !o_sequencer_port_b_write_busy;
    endproperty
    a_wbusy_end: assert property (p_wbusy_end) else $error("write busy stuck");
endmodule

// file: sim/srr_reader.sv
// srr_reader: user fabric model that fetches one 12-bit result in two reads
// assumes the read port answers one cycle after a sampled read enable
module srr_reader
    import srr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_start,
    input wire logic [SRR_SLOT_W-1:0] i_slot,
    input wire logic i_busy,
    input wire logic [SRR_DATA_W-1:0] i_data,
    output logic [SRR_ADDR_W-1:0] o_addr,
    output logic o_rd_en,
    output logic [SRR_RESULT_W-1:0] o_result,
    output logic o_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] st = 3'h0;
    logic [8:0] lo;
    initial
    begin
        o_addr = 9'h000;
        o_rd_en = 1'b0;
        o_done = 1'b0;
    end
    // address stays put when idle so the port never sees a floating pattern
    always @(posedge i_clk)
    begin
        o_done <= (st == 3'h3);
        if (st != 3'h0)
            st <= (st == 3'h3) ? 3'h0 : st + 3'h1;
        case (st)
            3'h0:
                if (i_start && !i_busy)
                begin
                    o_addr <= {i_slot, 1'b0};
                    o_rd_en <= 1'b1;
                    st <= 3'h1;
                end
            3'h1: o_addr <= o_addr + 9'h001;
            3'h2:
            begin
                o_rd_en <= 1'b0;
                lo <= i_data;
            end
            default: o_result <= {i_data[2:0], lo};
        endcase
    end
endmodule

// file: sim/sequencer_result_ram_read_port_test.sv
// sequencer_result_ram_read_port_test: stores conversions, reads them back
// assumes a raw build with the reader model on its user port, and a calibrated build beside it
module sequencer_result_ram_read_port_test
    import srr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    srr_conv_s conv = '0;
    logic int_req = 1'b0;
    logic [8:0] int_addr = 9'h000;
    logic start = 1'b0;
    logic [7:0] slot = 8'h00;
    logic [8:0] addr, data;
    logic rd_en, busy, wbusy, done;
    logic [11:0] result;
    logic [15:0] gain = 16'h0100;
    logic [15:0] offset = 16'h0000;
    logic [11:0] conv_result;
    logic [11:0] cal_result;
    logic conv_valid;
    logic conv_busy;
    logic cal_valid;
    logic cal_busy;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #10 clk = ~clk;
    srr_top #(.CAL_EN(1'b0)) dut_u (.i_clk(clk), .i_reset_n(reset_n), .i_ce(1'b1),
        .i_conv(conv), .i_cal_gain(gain), .i_cal_offset(offset),
        .i_internal_port_a_req(int_req), .i_internal_port_a_address(int_addr),
        .i_user_result_ram_address(addr), .i_user_result_ram_read_enable(rd_en),
        .o_result_ram_read_data(data), .o_result_ram_port_a_busy(busy),
        .o_sequencer_port_b_write_busy(wbusy), .o_conversion_result(conv_result),
        .o_conversion_valid(conv_valid), .o_conversion_busy(conv_busy));
    // calibrated build sees the same conversions; only its conversion result, valid and busy are judged
    srr_top #(.CAL_EN(1'b1)) dut_cal_u (.i_clk(clk), .i_reset_n(reset_n), .i_ce(1'b1),
        .i_conv(conv), .i_cal_gain(gain), .i_cal_offset(offset),
        .i_internal_port_a_req(1'b0), .i_internal_port_a_address(9'h000),
        .i_user_result_ram_address(9'h000), .i_user_result_ram_read_enable(1'b0),
        .o_result_ram_read_data(), .o_result_ram_port_a_busy(),
        .o_sequencer_port_b_write_busy(), .o_conversion_result(cal_result),
        .o_conversion_valid(cal_valid), .o_conversion_busy(cal_busy));
    srr_reader reader_u (.i_clk(clk), .i_start(start), .i_slot(slot), .i_busy(busy),
        .i_data(data), .o_addr(addr), .o_rd_en(rd_en), .o_result(result), .o_done(done));
    task automatic complete_run();
        if (fails == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // write busy spans exactly the two port b write cycles
    task automatic store(input logic [7:0] s, input logic [11:0] v);
        @(posedge clk) conv <= '{1'b1, s, v};
        @(posedge clk) conv.valid <= 1'b0;
        #1 chk(12'(wbusy), 12'h001);
        chk(conv_result, v);
        chk(12'(conv_valid), 12'h001);
        chk(12'(conv_busy), 12'h001);
        @(posedge clk) #1 chk(12'(wbusy), 12'h001);
        chk(12'(conv_valid), 12'h000);
        @(posedge clk) #1 chk(12'(wbusy), 12'h000);
    endtask
    // bounded wait on the reader's done pulse, sampled on the falling edge
    task automatic finish_read(input logic [11:0] exp);
        int n;
        n = 0;
        @(negedge clk);
        while (done !== 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        chk(12'(done), 12'h001);
        chk(result, exp);
    endtask
    task automatic fetch(input logic [7:0] s, input logic [11:0] exp);
        @(posedge clk) start <= 1'b1;
        slot <= s;
        @(posedge clk) start <= 1'b0;
        finish_read(exp);
    endtask
    task automatic t_raw();
        store(8'h00, 12'hC3A);
        store(8'hFF, 12'h5A5);
        fetch(8'h00, 12'hC3A);
        fetch(8'hFF, 12'h5A5);
    endtask
    // one channel in two slots, then one slot overwritten
    task automatic t_slots();
        store(8'h03, 12'h123);
        store(8'h04, 12'hABC);
        store(8'h03, 12'h777);
        fetch(8'h04, 12'hABC);
        fetch(8'h03, 12'h777);
    endtask
    // internal agent holds port a; the reader must stall until it lets go
    // the held start request is served only once busy has fallen
    task automatic t_busy();
        @(posedge clk) int_req <= 1'b1;
        int_addr <= 9'h007;
        @(posedge clk) start <= 1'b1;
        slot <= 8'h00;
        #1 chk(12'(busy), 12'h001);
        repeat (6) @(posedge clk);
        int_req <= 1'b0;
        #1 chk(12'(done), 12'h000);
        chk(12'(data), 12'h003);
        @(posedge clk) #1 chk(12'(busy), 12'h000);
        @(posedge clk) start <= 1'b0;
        finish_read(12'hC3A);
    endtask
    // reset in mid-run clears status but leaves stored results alone
    task automatic t_reset();
        @(posedge clk) int_req <= 1'b1;
        @(posedge clk) int_req <= 1'b0;
        reset_n <= 1'b0;
        #1 chk(12'(busy), 12'h001);
        @(posedge clk) reset_n <= 1'b1;
        #1 chk(12'(busy), 12'h000);
        chk(12'(wbusy), 12'h000);
        fetch(8'h04, 12'hABC);
    endtask
    // corrected value and valid appear fourteen cycles after the raw ones would
    task automatic cal_conv(input logic [11:0] v, input logic [11:0] exp);
        @(posedge clk) conv <= '{1'b1, 8'h10, v};
        @(posedge clk) conv.valid <= 1'b0;
        repeat (13) @(posedge clk);
        #1 chk(12'(cal_valid), 12'h000);
        @(posedge clk) #1 chk(12'(cal_valid), 12'h001);
        chk(cal_result, exp);
        chk(12'(cal_busy), 12'h001);
    endtask
    // gain 2.0 with a small offset, then a value that must saturate
    task automatic t_cal();
        @(posedge clk) gain <= 16'h0200;
        offset <= 16'h0010;
        cal_conv(12'h123, 12'h256);
        cal_conv(12'h900, 12'hFFF);
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            complete_run();
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        t_raw();
        t_slots();
        t_busy();
        t_reset();
        t_cal();
        complete_run();
    end
endmodule
